/* File: logic/toh_pkg.sv */
// Constants, types and functional notes for the transmit overhead source.
//
// Functional notes
// R01 - Selected all-zero T1 channels 1 to 24 get the zero code; others untouched.
// R02 - Data link byte goes out one bit per slot, bit 0 first, bit 7 last.
// R03 - In D4 framing only the six low data link bits are used.
// R04 - In D4 framing the data link byte supplies the Fs pattern bits.
// R05 - Bit-oriented code is six bits, bit 5 MSB; bits 7 and 6 read zero.
// R06 - Three loop link registers hold C, spoiler, M, A and S bits as laid out.
// R07 - Align word: Si in bit 7, alignment signal in 6..0, reset holds it.
// R08 - Non-align word: Si, fixed one, remote alarm, then Sa4 to Sa8.
// R09 - Even-frame Si register: bit 0 is frame 0, bit 7 is frame 14.
// R10 - Odd-frame Si register: bit 0 is frame 1, bit 7 is frame 15.
// R11 - Remote alarm register gives odd frames 1 to 15, bit 0 first.
// R12 - Sa4, Sa5 and Sa6 registers give odd frames 1 to 15, bit 0 first.
// R13 - Three addresses are loop link registers in T1, align/non-align/Si in E1.
// R14 - Every port has its own register copy at base plus stride per port.
// R15 - The substituted zero code is the fixed byte 10011000.
// R16 - Slot-0 bits come from registers unless pass-through takes the serial input.
// R17 - Data link bits come from registers, or from the HDLC source when selected.
// R18 - Registers read back last written value; frames change at next slot only. The code forces fixed fields on write, so BOC 0xFF reads back 0x3F.
// R19 - Software loads new values before the frame that must carry them.
package toh_pkg;

	// *****************************************************************
	// Register indexes; byte address is four times the index.
	// *****************************************************************
	localparam logic [8:0] IDX_ZC1 = 9'h108;
	localparam logic [8:0] IDX_ZC2 = 9'h109;
	localparam logic [8:0] IDX_ZC3 = 9'h10A;
	localparam logic [8:0] IDX_FDL = 9'h162;
	localparam logic [8:0] IDX_BOC = 9'h163;
	localparam logic [8:0] IDX_SHARED1 = 9'h164;
	localparam logic [8:0] IDX_SHARED2 = 9'h165;
	localparam logic [8:0] IDX_SHARED3 = 9'h166;
	localparam logic [8:0] IDX_SI_ODD = 9'h167;
	localparam logic [8:0] IDX_RA = 9'h168;
	localparam logic [8:0] IDX_SA4 = 9'h169;
	localparam logic [8:0] IDX_SA5 = 9'h16A;
	localparam logic [8:0] IDX_SA6 = 9'h16B;
	localparam logic [8:0] IDX_CTRL = 9'h170;
	localparam logic [8:0] IDX_STAT = 9'h171;
	localparam int PORT_IDX_STRIDE = 'h200;

	// *****************************************************************
	// Storage slots of one port.
	// *****************************************************************
	localparam logic [4:0] SL_FDL = 5'h00;
	localparam logic [4:0] SL_BOC = 5'h01;
	localparam logic [4:0] SL_SLC1 = 5'h02;
	localparam logic [4:0] SL_SLC2 = 5'h03;
	localparam logic [4:0] SL_SLC3 = 5'h04;
	localparam logic [4:0] SL_TAF = 5'h05;
	localparam logic [4:0] SL_TNAF = 5'h06;
	localparam logic [4:0] SL_SIE = 5'h07;
	localparam logic [4:0] SL_SIO = 5'h08;
	localparam logic [4:0] SL_RA = 5'h09;
	localparam logic [4:0] SL_SA4 = 5'h0A;
	localparam logic [4:0] SL_SA5 = 5'h0B;
	localparam logic [4:0] SL_SA6 = 5'h0C;
	localparam logic [4:0] SL_ZC1 = 5'h0D;
	localparam logic [4:0] SL_ZC2 = 5'h0E;
	localparam logic [4:0] SL_ZC3 = 5'h0F;
	localparam logic [4:0] SL_CTRL = 5'h10;
	localparam logic [4:0] SL_STAT = 5'h11;
	localparam logic [4:0] SL_NONE = 5'h1F;
	localparam int NSLOT = 17;

	// *****************************************************************
	// Reset values, fixed fields and control bit positions.
	// *****************************************************************
	localparam logic [7:0] RST_ZERO = 8'h00;
	localparam logic [7:0] RST_TAF = 8'h1B;
	localparam logic [7:0] RST_TNAF = 8'h40;
	localparam logic [7:0] RST_SLC2 = 8'h10;
	localparam logic [7:0] RST_SLC3 = 8'h80;
	localparam logic [2:0] SLC2_SPOILER = 3'h2;
	localparam logic [7:0] ZERO_CODE = 8'h98;
	localparam logic [7:0] CTRL_MASK = 8'h7F;
	localparam logic [2:0] FDL_D4_BITS = 3'h6;
	localparam logic [4:0] T1_CHANNELS = 5'h18;
	localparam int CB_E1 = 0;
	localparam int CB_D4 = 1;
	localparam int CB_ZCS = 2;
	localparam int CB_PASS = 3;
	localparam int CB_DLS = 4;
	localparam int CB_SLC = 5;
	localparam int CB_PERFRM = 6;

	// *****************************************************************
	// Stream beats.
	// *****************************************************************
	typedef enum logic [2:0] {
		K_CHAN,
		K_FDL,
		K_FS,
		K_BOC,
		K_TS0
	} toh_kind_t;

	typedef struct packed {
		logic [1:0] port;
		toh_kind_t kind;
		logic [4:0] chan;
		logic [3:0] frame;
		logic [2:0] bitpos;
		logic [7:0] data;
	} toh_in_t;

	typedef struct packed {
		logic [1:0] port;
		toh_kind_t kind;
		logic [7:0] data;
	} toh_out_t;

endpackage : toh_pkg

/* File: logic/toh_source.sv */
// Transmit overhead source: per-port registers, APB slave and insertion path.
//
// Chosen here: the APB register port.
`timescale 1ns/1ps
module toh_source import toh_pkg::*; #(
	parameter int PORTS = 4,
	parameter int ADDR_W = 14
) (
	input wire logic ref_clk, // 200 MHz clock.
	input wire logic rst_n, // Asynchronous reset, active low.
	input wire logic psel, // APB select.
	input wire logic penable, // APB access phase.
	input wire logic pwrite, // APB write when high.
	input wire logic [ADDR_W-1:0] paddr, // APB byte address.
	input wire logic [31:0] pwdata, // APB write data.
	output logic [31:0] prdata, // APB read data.
	output logic pready, // APB ready.
	output logic pslverr, // APB error on unmapped access.
	input wire logic in_valid, // Beat from the framer is valid.
	output logic in_ready, // Buffer can take a beat.
	input wire toh_in_t in_beat, // Beat from the framer.
	output logic out_valid, // Processed beat is valid.
	input wire logic out_ready, // Line side takes the beat.
	output toh_out_t out_beat // Processed beat.
);

	// *****************************************************************
	// Elaboration checks.
	// *****************************************************************
	if (PORTS < 1 || PORTS > 4 || ADDR_W != 14) begin : g_bad_params
		$error("PORTS must lie in 1 to 4 and ADDR_W must be 14.");
	end

	// *****************************************************************
	// Decoding helpers.
	// *****************************************************************

	// Maps a register index to a storage slot; shared indexes follow the mode.
	function automatic logic [4:0] toh_decode(input logic [8:0] loc,
			input logic e1);
		logic [4:0] s;
		s = SL_NONE;
		unique case (loc)
			IDX_ZC1: s = SL_ZC1;
			IDX_ZC2: s = SL_ZC2;
			IDX_ZC3: s = SL_ZC3;
			IDX_FDL: s = SL_FDL;
			IDX_BOC: s = SL_BOC;
			IDX_SHARED1: s = e1 ? SL_TAF : SL_SLC1; // [R13]
			IDX_SHARED2: s = e1 ? SL_TNAF : SL_SLC2; // [R13]
			IDX_SHARED3: s = e1 ? SL_SIE : SL_SLC3; // [R13]
			IDX_SI_ODD: s = SL_SIO;
			IDX_RA: s = SL_RA;
			IDX_SA4: s = SL_SA4;
			IDX_SA5: s = SL_SA5;
			IDX_SA6: s = SL_SA6;
			IDX_CTRL: s = SL_CTRL;
			IDX_STAT: s = SL_STAT;
			default: s = SL_NONE;
		endcase
		return s;
	endfunction : toh_decode

	// Gives the reset value of a storage slot.
	function automatic logic [7:0] toh_reset_val(input logic [4:0] s);
		logic [7:0] v;
		unique case (s)
			SL_TAF: v = RST_TAF; // [R07]
			SL_TNAF: v = RST_TNAF;
			SL_SLC2: v = RST_SLC2;
			SL_SLC3: v = RST_SLC3;
			default: v = RST_ZERO;
		endcase
		return v;
	endfunction : toh_reset_val

	// Forces the fixed fields of a written value.
	function automatic logic [7:0] toh_fix(input logic [4:0] s,
			input logic [7:0] w);
		logic [7:0] v;
		unique case (s)
			SL_BOC: v = {2'b00, w[5:0]}; // [R05]
			SL_SLC2: v = {w[7:6], SLC2_SPOILER, w[2:0]}; // [R06]
			SL_SLC3: v = {1'b1, w[6:0]}; // [R06]
			SL_TNAF: v = {w[7], 1'b1, w[5:0]}; // [R08]
			SL_CTRL: v = w & CTRL_MASK;
			default: v = w;
		endcase
		return v;
	endfunction : toh_fix

	// *****************************************************************
	// Register storage.
	// *****************************************************************
	logic [7:0] rf_r [PORTS][NSLOT];
	logic [7:0] last_out_r [PORTS];
	logic pready_r;
	logic pslverr_r;
	logic [31:0] prdata_r;
	logic [1:0] apb_port;
	logic [8:0] apb_loc;
	logic apb_port_ok;
	logic apb_e1;
	logic [4:0] apb_slot;
	logic apb_hit;
	logic [7:0] apb_rd;
	logic apb_wr;

	// Address decode: port from the upper index bits, register below.
	assign apb_port = paddr[12:11];
	assign apb_loc = paddr[10:2];
	assign apb_port_ok = ({30'h0, apb_port} < PORTS); // [R14]
	assign apb_e1 = apb_port_ok ? rf_r[apb_port][SL_CTRL][CB_E1] : 1'b0;
	assign apb_slot = toh_decode(apb_loc, apb_e1);
	assign apb_hit = !paddr[13] && paddr[1:0] == 2'b00 && apb_port_ok &&
		apb_slot != SL_NONE;
	assign apb_wr = psel && penable && pready_r && pwrite && !pslverr_r;

	// Read data selection; the status slot shows the last processed byte accepted for that port.
	always_comb begin
		apb_rd = 8'h00;
		if (apb_hit && apb_slot == SL_STAT) begin
			apb_rd = last_out_r[apb_port];
		end else if (apb_hit) begin
			apb_rd = rf_r[apb_port][apb_slot]; // [R18]
		end
	end

	// Answers in the first access cycle with data sampled in setup.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
			prdata_r <= 32'h0000_0000;
		end else if (psel && !penable) begin
			pready_r <= 1'b1;
			pslverr_r <= !apb_hit || (pwrite && apb_slot == SL_STAT);
			prdata_r <= {24'h00_0000, apb_rd};
		end else begin
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
		end
	end

	// Register writes land at the completing access edge.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int p = 0; p < PORTS; p++) begin
				for (int s = 0; s < NSLOT; s++) begin
					rf_r[p][s] <= toh_reset_val(5'(s));
				end
			end
		end else if (apb_wr) begin
			rf_r[apb_port][apb_slot] <= toh_fix(apb_slot, pwdata[7:0]); // [R18]
		end
	end

	assign prdata = prdata_r;
	assign pready = pready_r;
	assign pslverr = pslverr_r;

	// *****************************************************************
	// Overhead insertion path.
	// *****************************************************************
	toh_out_t proc;
	logic [7:0] cfg;
	logic [23:0] zc_sel;
	logic [23:0] slc_bits;
	logic [4:0] slc_idx;
	logic [2:0] fh;
	logic in_port_ok;

	assign in_port_ok = ({30'h0, in_beat.port} < PORTS); // [R14]
	assign fh = in_beat.frame[3:1];
	assign slc_idx = {in_beat.frame[1:0], in_beat.bitpos};

	// Works out the outgoing byte or bit from the port's registers.
	always_comb begin
		proc.port = in_beat.port;
		proc.kind = in_beat.kind;
		proc.data = in_beat.data;
		cfg = 8'h00;
		zc_sel = 24'h00_0000;
		slc_bits = 24'h00_0000;
		if (in_port_ok) begin
			cfg = rf_r[in_beat.port][SL_CTRL];
			zc_sel = {rf_r[in_beat.port][SL_ZC3], rf_r[in_beat.port][SL_ZC2],
				rf_r[in_beat.port][SL_ZC1]};
			slc_bits = {rf_r[in_beat.port][SL_SLC3],
				rf_r[in_beat.port][SL_SLC2], rf_r[in_beat.port][SL_SLC1]};
			unique case (in_beat.kind)
				K_CHAN: begin
					if (!cfg[CB_E1] && cfg[CB_ZCS] && in_beat.chan < T1_CHANNELS &&
							zc_sel[in_beat.chan] && in_beat.data == 8'h00) begin
						proc.data = ZERO_CODE; // [R01] [R15]
					end
				end
				K_FDL: begin
					if (cfg[CB_DLS]) begin
						proc.data = {7'h00, in_beat.data[0]}; // [R17]
					end else if (cfg[CB_D4] && in_beat.bitpos >= FDL_D4_BITS) begin
						proc.data = 8'h00; // [R03]
					end else begin
						proc.data = {7'h00,
							rf_r[in_beat.port][SL_FDL][in_beat.bitpos]}; // [R02]
					end
				end
				K_FS: begin
					if (cfg[CB_DLS]) begin
						proc.data = {7'h00, in_beat.data[0]}; // [R17]
					end else if (cfg[CB_SLC]) begin
						proc.data = {7'h00, slc_idx < T1_CHANNELS ?
							slc_bits[slc_idx] : 1'b0}; // [R06]
					end else if (in_beat.bitpos >= FDL_D4_BITS) begin
						proc.data = 8'h00; // [R03]
					end else begin
						proc.data = {7'h00,
							rf_r[in_beat.port][SL_FDL][in_beat.bitpos]}; // [R04]
					end
				end
				K_BOC: begin
					proc.data = {2'b00, rf_r[in_beat.port][SL_BOC][5:0]}; // [R05]
				end
				K_TS0: begin
					if (cfg[CB_PASS]) begin
						proc.data = in_beat.data; // [R16]
					end else if (!in_beat.frame[0]) begin
						proc.data = rf_r[in_beat.port][SL_TAF]; // [R07] [R16]
						if (cfg[CB_PERFRM]) begin
							proc.data[7] = rf_r[in_beat.port][SL_SIE][fh]; // [R09]
						end
					end else begin
						proc.data = rf_r[in_beat.port][SL_TNAF]; // [R08] [R16]
						proc.data[6] = 1'b1; // [R08]
						if (cfg[CB_PERFRM]) begin
							proc.data[7] = rf_r[in_beat.port][SL_SIO][fh]; // [R10]
							proc.data[5] = rf_r[in_beat.port][SL_RA][fh]; // [R11]
							proc.data[4] = rf_r[in_beat.port][SL_SA4][fh]; // [R12]
							proc.data[3] = rf_r[in_beat.port][SL_SA5][fh]; // [R12]
							proc.data[2] = rf_r[in_beat.port][SL_SA6][fh]; // [R12]
						end
					end
				end
				default: begin
					proc.data = in_beat.data;
				end
			endcase
		end
	end

	// *****************************************************************
	// Two-entry buffer: output register plus one skid entry.
	// *****************************************************************
	logic in_ready_r;
	logic out_valid_r;
	toh_out_t out_r;
	logic skid_valid_r;
	toh_out_t skid_r;
	logic accept;
	logic skid_valid_nxt;

	assign accept = in_valid && in_ready_r;

	// The skid entry fills only when the line side stalls.
	always_comb begin
		skid_valid_nxt = skid_valid_r;
		if (!out_valid_r || out_ready) begin
			skid_valid_nxt = 1'b0;
		end else if (accept) begin
			skid_valid_nxt = 1'b1;
		end
	end

	// Moves beats through the two entries in arrival order.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			out_valid_r <= 1'b0;
			out_r <= '0;
			skid_r <= '0;
		end else if (!out_valid_r || out_ready) begin
			if (skid_valid_r) begin
				out_r <= skid_r;
				out_valid_r <= 1'b1;
			end else begin
				out_valid_r <= accept;
				if (accept) begin
					out_r <= proc;
				end
			end
		end else if (accept) begin
			skid_r <= proc;
		end
	end

	// Ready falls as soon as the skid entry holds a beat.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			skid_valid_r <= 1'b0;
			in_ready_r <= 1'b0;
		end else begin
			skid_valid_r <= skid_valid_nxt;
			in_ready_r <= !skid_valid_nxt;
		end
	end

	// Keeps the last processed byte of each port for the status register.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int p = 0; p < PORTS; p++) begin
				last_out_r[p] <= 8'h00;
			end
		end else if (accept && in_port_ok) begin
			last_out_r[in_beat.port] <= proc.data;
		end
	end

	assign in_ready = in_ready_r;
	assign out_valid = out_valid_r;
	assign out_beat = out_r;

	// *****************************************************************
	// Assertions.
	// *****************************************************************
	property p_zero_code;
		@(posedge ref_clk) disable iff (!rst_n)
		accept && in_port_ok && in_beat.kind == K_CHAN && cfg[CB_ZCS] &&
			!cfg[CB_E1] && in_beat.chan < T1_CHANNELS &&
			zc_sel[in_beat.chan] && in_beat.data == 8'h00 |=>
			(out_r.data == ZERO_CODE || skid_r.data == ZERO_CODE);
	endproperty
	a_zero_code: assert property (p_zero_code) // [R01] [R15]
		else $error("Zero code not substituted.");
	property p_chan_untouched;
		@(posedge ref_clk) disable iff (!rst_n)
		accept && in_beat.kind == K_CHAN && in_port_ok &&
			in_beat.chan < T1_CHANNELS && !zc_sel[in_beat.chan] |=>
			(out_r.data == $past(in_beat.data) ||
			skid_r.data == $past(in_beat.data));
	endproperty
	a_chan_untouched: assert property (p_chan_untouched) // [R01]
		else $error("Unselected channel was altered.");
	property p_fdl_bit;
		@(posedge ref_clk) disable iff (!rst_n)
		in_valid && in_port_ok && in_beat.kind == K_FDL && !cfg[CB_DLS] &&
			!cfg[CB_D4] |->
			proc.data == {7'h00, rf_r[in_beat.port][SL_FDL][in_beat.bitpos]};
	endproperty
	a_fdl_bit: assert property (p_fdl_bit) // [R02]
		else $error("Data link bit taken from wrong position.");
	property p_d4_upper;
		@(posedge ref_clk) disable iff (!rst_n)
		in_valid && in_port_ok && in_beat.kind == K_FS && !cfg[CB_DLS] &&
			!cfg[CB_SLC] && in_beat.bitpos >= FDL_D4_BITS |-> proc.data == 8'h00;
	endproperty
	a_d4_upper: assert property (p_d4_upper) // [R03]
		else $error("Upper data link bits used in D4.");
	property p_boc_width;
		@(posedge ref_clk) disable iff (!rst_n)
		apb_wr && apb_slot == SL_BOC |=>
			rf_r[$past(apb_port)][SL_BOC] == {2'b00, $past(pwdata[5:0])};
	endproperty
	a_boc_width: assert property (p_boc_width) // [R05] [R18]
		else $error("Bit-oriented code register stored wrong value.");
	property p_nonalign_fixed;
		@(posedge ref_clk) disable iff (!rst_n)
		in_valid && in_port_ok && in_beat.kind == K_TS0 && !cfg[CB_PASS] &&
			in_beat.frame[0] |-> proc.data[6];
	endproperty
	a_nonalign_fixed: assert property (p_nonalign_fixed) // [R08]
		else $error("Non-align word lost its fixed one.");
	property p_pass_through;
		@(posedge ref_clk) disable iff (!rst_n)
		in_valid && in_port_ok && in_beat.kind == K_TS0 && cfg[CB_PASS] |->
			proc.data == in_beat.data;
	endproperty
	a_pass_through: assert property (p_pass_through) // [R16]
		else $error("Pass-through slot 0 not taken from input.");
	property p_link_source;
		@(posedge ref_clk) disable iff (!rst_n)
		in_valid && in_port_ok && in_beat.kind == K_FDL && cfg[CB_DLS] |->
			proc.data == {7'h00, in_beat.data[0]};
	endproperty
	a_link_source: assert property (p_link_source) // [R17]
		else $error("Data link not taken from HDLC source.");
	property p_ready_pulse;
		@(posedge ref_clk) disable iff (!rst_n)
		psel && !penable |=> pready_r ##1 !pready_r;
	endproperty
	a_ready_pulse: assert property (p_ready_pulse) // [R18]
		else $error("APB ready not a single access cycle.");
	property p_backpressure;
		@(posedge ref_clk) disable iff (!rst_n)
		out_valid_r && !out_ready && accept |=> !in_ready_r && skid_valid_r;
	endproperty
	a_backpressure: assert property (p_backpressure)
		else $error("Stall did not reach the input.");

endmodule : toh_source

/* File: sim/toh_line_model.sv */
// Line-side partner model that takes processed overhead beats.
`timescale 1ns/1ps
module toh_line_model import toh_pkg::*; (
	input wire logic ref_clk, // 200 MHz clock.
	input wire logic rst_n, // Asynchronous reset, active low.
	input wire logic stall, // Holds the line side off when high.
	input wire logic out_valid, // Beat offered by the source.
	input wire toh_out_t out_beat, // Offered beat.
	output logic out_ready, // Line side takes beats.
	output logic got, // One-cycle pulse for each beat taken.
	output logic [7:0] got_data // Data of the beat taken.
);

	// *****************************************************************
	// Ready follows the stall request one cycle late, like a slow line.
	// *****************************************************************
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			out_ready <= 1'b0;
		end else begin
			out_ready <= !stall;
		end
	end

	// Capture each accepted beat; idle data toggles so it is never stale.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			got <= 1'b0;
			got_data <= 8'h00;
		end else begin
			got <= out_valid && out_ready;
			got_data <= (out_valid && out_ready) ? out_beat.data : ~got_data;
		end
	end

endmodule : toh_line_model

/* File: sim/toh_source_tb_top.sv */
// Self-checking bench for the transmit overhead source.
`timescale 1ns/1ps
module toh_source_tb_top import toh_pkg::*;;
	logic ref_clk, rst_n, psel, penable, pwrite, pready, pslverr;
	logic [13:0] paddr;
	logic [31:0] pwdata, prdata, rdat;
	logic in_valid, in_ready, out_valid, out_ready, stall, got, rerr;
	logic [7:0] got_data;
	toh_in_t in_beat;
	toh_out_t out_beat;
	logic [7:0] rxq[$];
	logic [7:0] expq[$];
	logic [7:0] fdlv;
	int n_fail, checked, cyc;

	toh_source uut (.ref_clk(ref_clk), .rst_n(rst_n), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.in_valid(in_valid), .in_ready(in_ready), .in_beat(in_beat),
		.out_valid(out_valid), .out_ready(out_ready), .out_beat(out_beat));
	toh_line_model line (.ref_clk(ref_clk), .rst_n(rst_n), .stall(stall),
		.out_valid(out_valid), .out_beat(out_beat), .out_ready(out_ready),
		.got(got), .got_data(got_data));

	// *****************************************************************
	// Clock, watchdog and collection of beats seen on the line.
	// *****************************************************************
	initial begin
		ref_clk = 1'b0;
		forever #2.5 ref_clk = ~ref_clk;
	end
	always @(posedge ref_clk) begin
		cyc++;
		if (got === 1'b1) rxq.push_back(got_data);
		if (cyc == 20000) begin
			n_fail++;
			close_out();
		end
	end

	// Prints the counts and the verdict, then ends the run.
	task close_out();
		$display("checked=%0d n_fail=%0d", checked, n_fail);
		if (n_fail == 0 && checked > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : close_out

	task check(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			n_fail++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	// One APB transfer; an idle cycle follows so psel drops cleanly.
	task apb(input logic [1:0] p, input logic w, input logic [8:0] idx,
		input logic [7:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= {1'b0, p, idx, 2'b00};
		pwdata <= {24'h000000, d};
		@(posedge ref_clk);
		penable <= 1'b1;
		do @(posedge ref_clk); while (pready !== 1'b1);
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge ref_clk);
	endtask : apb

	task wr(input logic [1:0] p, input logic [8:0] idx, input logic [7:0] d);
		apb(p, 1'b1, idx, d);
	endtask : wr

	task rd_chk(input logic [1:0] p, input logic [8:0] idx,
		input logic [7:0] e);
		apb(p, 1'b0, idx, 8'h00);
		check(rdat, {24'h000000, e});
	endtask : rd_chk

	// Offers one beat, leaving valid up until the caller stops.
	task beat(input logic [1:0] p, input toh_kind_t k, input logic [4:0] ch,
		input logic [3:0] fr, input logic [2:0] bp, input logic [7:0] d,
		input logic [7:0] e);
		in_valid <= 1'b1;
		in_beat <= {p, k, ch, fr, bp, d};
		expq.push_back(e);
		do @(posedge ref_clk); while (in_ready !== 1'b1);
	endtask : beat

	task stop();
		in_valid <= 1'b0;
		@(posedge ref_clk);
	endtask : stop

	// Waits for every offered beat and compares them in arrival order.
	task flush();
		stop();
		while (rxq.size() < expq.size()) @(posedge ref_clk);
		while (expq.size() > 0) check({24'h0, rxq.pop_front()},
			{24'h0, expq.pop_front()});
	endtask : flush

	// *****************************************************************
	// Main sequence.
	// *****************************************************************
	initial begin
		rst_n = 1'b0;
		{psel, penable, pwrite, in_valid, stall} = 5'h00;
		paddr = 14'h0000;
		pwdata = 32'h00000000;
		in_beat = '0;
		repeat (10) @(posedge ref_clk);
		rst_n <= 1'b1;
		@(posedge ref_clk);
		rd_chk(2'h0, IDX_FDL, 8'h00);
		rd_chk(2'h0, IDX_BOC, 8'h00);
		rd_chk(2'h0, IDX_SHARED2, 8'h10);
		rd_chk(2'h0, IDX_SHARED3, 8'h80);
		wr(2'h1, IDX_CTRL, 8'h01);
		rd_chk(2'h1, IDX_SHARED1, 8'h1B);
		rd_chk(2'h1, IDX_SHARED2, 8'h40);
		rd_chk(2'h1, IDX_SHARED3, 8'h00);
		wr(2'h0, IDX_BOC, 8'hFF);
		rd_chk(2'h0, IDX_BOC, 8'h3F);
		wr(2'h0, IDX_SHARED2, 8'h00);
		rd_chk(2'h0, IDX_SHARED2, 8'h10);
		wr(2'h0, IDX_SHARED3, 8'h00);
		rd_chk(2'h0, IDX_SHARED3, 8'h80);
		wr(2'h1, IDX_SHARED2, 8'h00);
		rd_chk(2'h1, IDX_SHARED2, 8'h40);
		fdlv = 8'hA5;
		wr(2'h0, IDX_FDL, fdlv);
		wr(2'h2, IDX_FDL, 8'h3C);
		rd_chk(2'h0, IDX_FDL, 8'hA5);
		rd_chk(2'h2, IDX_FDL, 8'h3C);
		wr(2'h0, IDX_SHARED1, 8'h11);
		wr(2'h1, IDX_SHARED1, 8'h9B);
		rd_chk(2'h0, IDX_SHARED1, 8'h11);
		rd_chk(2'h1, IDX_SHARED1, 8'h9B);
		// Unmapped read and a write to the read-only status are refused.
		rd_chk(2'h0, 9'h100, 8'h00);
		check({31'h0, rerr}, 32'h1);
		wr(2'h0, IDX_STAT, 8'h55);
		check({31'h0, rerr}, 32'h1);
		// Data link byte goes out low bit first.
		for (int i = 0; i < 8; i++) begin
			beat(2'h0, K_FDL, 5'h00, 4'h0, i[2:0], 8'h00, {7'h0, fdlv[i]});
		end
		beat(2'h0, K_BOC, 5'h00, 4'h0, 3'h0, 8'h00, 8'h3F);
		flush();
		wr(2'h0, IDX_CTRL, 8'h02);
		beat(2'h0, K_FDL, 5'h00, 4'h0, 3'h7, 8'h00, 8'h00);
		beat(2'h0, K_FS, 5'h00, 4'h0, 3'h5, 8'h00, 8'h01);
		beat(2'h0, K_FS, 5'h00, 4'h0, 3'h7, 8'h00, 8'h00);
		flush();
		wr(2'h0, IDX_CTRL, 8'h12);
		beat(2'h0, K_FDL, 5'h00, 4'h0, 3'h0, 8'h00, 8'h00);
		beat(2'h0, K_FS, 5'h00, 4'h0, 3'h7, 8'h01, 8'h01);
		flush();
		// Loop link bits {link3, link2, link1} indexed by frame and bit.
		wr(2'h0, IDX_CTRL, 8'h22);
		beat(2'h0, K_FS, 5'h00, 4'h2, 3'h7, 8'h00, 8'h01);
		beat(2'h0, K_FS, 5'h00, 4'h1, 3'h4, 8'h00, 8'h01);
		beat(2'h0, K_FS, 5'h00, 4'h1, 3'h5, 8'h00, 8'h00);
		beat(2'h0, K_FS, 5'h00, 4'h0, 3'h0, 8'h00, 8'h01);
		flush();
		wr(2'h0, IDX_CTRL, 8'h04);
		wr(2'h0, IDX_ZC1, 8'h01);
		wr(2'h0, IDX_ZC3, 8'h80);
		beat(2'h0, K_CHAN, 5'h00, 4'h0, 3'h0, 8'h00, 8'h98);
		beat(2'h0, K_CHAN, 5'h01, 4'h0, 3'h0, 8'h00, 8'h00);
		beat(2'h0, K_CHAN, 5'h00, 4'h0, 3'h0, 8'h01, 8'h01);
		beat(2'h0, K_CHAN, 5'h17, 4'h0, 3'h0, 8'h00, 8'h98);
		flush();
		wr(2'h0, IDX_CTRL, 8'h00);
		beat(2'h0, K_CHAN, 5'h00, 4'h0, 3'h0, 8'h00, 8'h00);
		flush();
		// Per-frame sources are loaded before the frames that use them.
		wr(2'h1, IDX_CTRL, 8'h41);
		wr(2'h1, IDX_SHARED3, 8'h80);
		wr(2'h1, IDX_SI_ODD, 8'h80);
		wr(2'h1, IDX_RA, 8'h01);
		wr(2'h1, IDX_SA4, 8'h02);
		wr(2'h1, IDX_SA5, 8'h80);
		wr(2'h1, IDX_SA6, 8'h01);
		beat(2'h1, K_TS0, 5'h00, 4'h0, 3'h0, 8'h00, 8'h1B);
		beat(2'h1, K_TS0, 5'h00, 4'hE, 3'h0, 8'h00, 8'h9B);
		beat(2'h1, K_TS0, 5'h00, 4'h1, 3'h0, 8'h00, 8'h64);
		beat(2'h1, K_TS0, 5'h00, 4'hF, 3'h0, 8'h00, 8'hC8);
		beat(2'h1, K_TS0, 5'h00, 4'h3, 3'h0, 8'h00, 8'h50);
		flush();
		wr(2'h1, IDX_CTRL, 8'h09);
		beat(2'h1, K_TS0, 5'h00, 4'h1, 3'h0, 8'h5A, 8'h5A);
		flush();
		wr(2'h1, IDX_CTRL, 8'h01);
		beat(2'h1, K_TS0, 5'h00, 4'h1, 3'h0, 8'h5A, 8'h40);
		beat(2'h1, K_TS0, 5'h00, 4'h0, 3'h0, 8'h5A, 8'h9B);
		flush();
		// The status word shows the last processed byte that port accepted.
		rd_chk(2'h1, IDX_STAT, 8'h9B);
		// Two beats held while the line stalls; the buffer then refuses.
		stall <= 1'b1;
		beat(2'h0, K_BOC, 5'h00, 4'h0, 3'h0, 8'h00, 8'h3F);
		beat(2'h0, K_CHAN, 5'h02, 4'h0, 3'h0, 8'h21, 8'h21);
		stop();
		repeat (3) @(posedge ref_clk);
		check({31'h0, in_ready}, 32'h0);
		check({31'h0, out_valid}, 32'h1);
		check({27'h0, out_beat.port, out_beat.kind}, {27'h0, 2'h0, K_BOC});
		stall <= 1'b0;
		beat(2'h0, K_CHAN, 5'h03, 4'h0, 3'h0, 8'h42, 8'h42);
		flush();
		close_out();
	end

endmodule : toh_source_tb_top
